// ### core/ctm_timer.v
// Compact 10-bit timer with compare A / period P comparators and PWM
// Behaviour
// - output_invert set inverts the pin; no effect in timer/counter mode.
// - Swap 0: period bits give period, compare A duty; swap 1 exchanges.
// - clear_select 1 clears on A match; 0 clears on P match or overflow.
// - Overflow clearing applies with clear_select 0, whatever the period bits.
// - PWM mode ignores clear_select entirely.
// - Mode 00 compare output, 10 PWM, 11 timer/counter.
// - Compare mode, clear_select 0: A flag on A match, P flag on P match with period bits nonzero.
// - Compare mode, clear_select 1: only A flag, never P flag.
// - clear_select 1, compare A zero: counter wraps at 3FF, no A flag.
// - Compare mode: only A match changes the pin.
// - A match drives pin high, low, toggles, or none per pin action.
// - counter_on rising edge loads pin with initial_level.
// - Timer/counter mode counts and flags like compare mode, pin unused.
// - PWM mode sets A flag on A match, P flag on P match.
// - PWM: initial_level picks active level; pin action enables or forces.
// - Swap 0 period: 001..111 give 128..896 clocks, 000 gives 1024.
// - Duty at or above period holds output active all period.
// - Swap 1: compare A sets period, period bits give duty times 128.
// - PWM generation, clearing and flags continue while pin is forced.
// - Compare mode pin action: 00 none, 01 low, 10 high, 11 toggle.
// - PWM pin action: 00 inactive, 01 active, 10 waveform, 11 inactive.
// - counter_on rise zeroes counter; fall keeps its value.
// - P match when period bits equal counter bits 9 to 7.
`timescale 1ns/1ps
`include "ctm_defs.vh"

module ctm_timer (
   // Clock and reset
   input  wire       mclk,
   input  wire       rst,
   // Timer count enable, one pulse per selected timer clock
   input  wire       tick,
   // Register port
   input  wire [2:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // Output pin
   output wire       timer_out_pin0,
   output wire       timer_out_pin1,
   output wire       timer_out_oe,
   // Match events
   output wire       match_a_flag,
   output wire       match_p_flag
);

   reg  [7:0] ctrl0_q;
   reg  [7:0] ctrl1_q;
   reg  [9:0] compare_a_value_q;
   reg  [9:0] count_q;
   reg  [9:0] count_d;
   reg        on_prev_q;
   reg        pin_q;
   reg        pin_d;
   reg        flag_a_q;
   reg        flag_p_q;
   reg        set_a;
   reg        set_p;
   reg        do_clear;
   reg        pwm_active;

   wire       counter_on       = ctrl0_q[`CTM_C0_ON_BIT];
   wire [2:0] period_bits      = ctrl0_q[`CTM_C0_RP_MSB:`CTM_C0_RP_LSB];
   wire [1:0] mode             = ctrl1_q[`CTM_C1_MODE_MSB:`CTM_C1_MODE_LSB];
   wire [1:0] pin_action       = ctrl1_q[`CTM_C1_IO_MSB:`CTM_C1_IO_LSB];
   wire       initial_level    = ctrl1_q[`CTM_C1_OC_BIT];
   wire       output_invert    = ctrl1_q[`CTM_C1_POL_BIT];
   wire       period_duty_swap = ctrl1_q[`CTM_C1_DPX_BIT];
   wire       clear_select     = ctrl1_q[`CTM_C1_CCLR_BIT];

   wire       is_cmp = (mode == `CTM_MODE_CMP);
   wire       is_pwm = (mode == `CTM_MODE_PWM);
   wire       is_tmr = (mode == `CTM_MODE_TMR);
   wire       on_rise = counter_on & ~on_prev_q;

   // Period bits as an 11-bit clock count, zero meaning the full 1024
   function [10:0] rp_count;
      input [2:0] rp;
      begin
         rp_count = (rp == 3'h0) ? 11'h400 : {1'b0, rp, 7'h00};
      end
   endfunction

   wire       match_a = (count_q == compare_a_value_q);
   wire       match_p = (count_q[9:7] == period_bits);
   wire       at_max  = (count_q == `CTM_CNT_MAX);
   // Counter is at the last clock of a period of n clocks
   wire [10:0] cnt_next  = {1'b0, count_q} + 11'h001;
   wire [10:0] p_len     = rp_count(period_bits);
   wire [10:0] a_len     = (compare_a_value_q == 10'h000) ? 11'h400 : {1'b0, compare_a_value_q};

   // Counter, clear and flag event logic
   always @* begin
      set_a      = 1'b0;
      set_p      = 1'b0;
      do_clear   = 1'b0;
      pwm_active = 1'b0;
      count_d    = count_q;
      if (is_pwm) begin
         // Comparator holding the period clears (P with swap 0, A with swap 1); clear_select not consulted here
         if (!period_duty_swap) begin
            do_clear   = (cnt_next == p_len);
            pwm_active = ({1'b0, compare_a_value_q} >= p_len) |
                         ({1'b0, count_q} < {1'b0, compare_a_value_q});
         end else begin
            do_clear   = (cnt_next == a_len);
            pwm_active = (p_len >= a_len) | ({1'b0, count_q} < p_len);
         end
         // The clearing comparator never sees its value, so its match is the period end
         if (!period_duty_swap) begin
            set_a = tick & counter_on & match_a;
            set_p = tick & counter_on & (cnt_next == p_len);
         end else begin
            set_a = tick & counter_on & (cnt_next == a_len);
            set_p = tick & counter_on & match_p;
         end
      end else if (is_cmp | is_tmr) begin
         if (clear_select) begin
            // A value of zero lets the counter run to 3FF with no flag
            set_a    = tick & counter_on & match_a & (compare_a_value_q != 10'h000);
            do_clear = match_a & (compare_a_value_q != 10'h000);
         end else begin
            set_a    = tick & counter_on & match_a;
            set_p    = tick & counter_on & match_p & (period_bits != 3'h0);
            do_clear = (match_p & (period_bits != 3'h0)) | at_max;
         end
      end
      if (tick & counter_on) begin
         if (do_clear)
            count_d = `CTM_RST_CNT;
         else
            count_d = cnt_next[9:0];
      end
      if (on_rise)
         count_d = `CTM_RST_CNT;
   end

   // Compare mode pin action on A match
   always @* begin
      pin_d = pin_q;
      if (on_rise) begin
         pin_d = initial_level;
      end else if (is_cmp & set_a) begin
         case (pin_action)
            `CTM_IO_LOW:    pin_d = 1'b0;
            `CTM_IO_HIGH:   pin_d = 1'b1;
            `CTM_IO_TOGGLE: pin_d = ~pin_q;
            default:        pin_d = pin_q;
         endcase
      end
   end

   // Pin level before polarity
   reg pin_raw;
   always @* begin
      pin_raw = pin_q;
      if (is_pwm) begin
         case (pin_action)
            `CTM_IO_FORCE_OFF: pin_raw = ~initial_level;
            `CTM_IO_FORCE_ON:  pin_raw = initial_level;
            `CTM_IO_PWM:       pin_raw = pwm_active ? initial_level : ~initial_level;
            default:           pin_raw = ~initial_level;
         endcase
      end
   end

   reg pin_out_q;
   assign timer_out_pin0 = pin_out_q;
   assign timer_out_pin1 = pin_out_q;
   assign timer_out_oe   = ~is_tmr;
   assign match_a_flag   = flag_a_q;
   assign match_p_flag   = flag_p_q;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl0_q           <= `CTM_RST_CTRL;
         ctrl1_q           <= `CTM_RST_CTRL;
         compare_a_value_q <= `CTM_RST_CNT;
         count_q           <= `CTM_RST_CNT;
         on_prev_q         <= 1'b0;
         pin_q             <= 1'b0;
         pin_out_q         <= 1'b0;
         flag_a_q          <= 1'b0;
         flag_p_q          <= 1'b0;
         reg_rdata         <= 8'h00;
      end else begin
         on_prev_q <= counter_on;
         count_q   <= count_d;
         pin_q     <= pin_d;
         // Polarity only matters where the pin is driven
         pin_out_q <= is_tmr ? 1'b0 : (pin_raw ^ output_invert);
         // Hardware set wins over a software clear in the same cycle
         if (reg_wr && reg_addr == `CTM_OFS_FLAGS) begin
            flag_a_q <= set_a | (flag_a_q & ~reg_wdata[`CTM_FL_A_BIT]);
            flag_p_q <= set_p | (flag_p_q & ~reg_wdata[`CTM_FL_P_BIT]);
         end else begin
            flag_a_q <= flag_a_q | set_a;
            flag_p_q <= flag_p_q | set_p;
         end
         if (reg_wr) begin
            case (reg_addr)
               `CTM_OFS_CTRL0:   ctrl0_q <= reg_wdata;
               `CTM_OFS_CTRL1:   ctrl1_q <= reg_wdata;
               `CTM_OFS_CMPA_LO: compare_a_value_q[7:0] <= reg_wdata;
               `CTM_OFS_CMPA_HI: compare_a_value_q[9:8] <= reg_wdata[1:0];
               default: ;
            endcase
         end
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `CTM_OFS_CTRL0:   reg_rdata <= ctrl0_q;
               `CTM_OFS_CTRL1:   reg_rdata <= ctrl1_q;
               `CTM_OFS_CNT_LO:  reg_rdata <= count_q[7:0];
               `CTM_OFS_CNT_HI:  reg_rdata <= {6'h00, count_q[9:8]};
               `CTM_OFS_CMPA_LO: reg_rdata <= compare_a_value_q[7:0];
               `CTM_OFS_CMPA_HI: reg_rdata <= {6'h00, compare_a_value_q[9:8]};
               `CTM_OFS_FLAGS:   reg_rdata <= {6'h00, flag_p_q, flag_a_q};
               default:          reg_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule // ctm_timer

// ### inc/ctm_defs.vh
// Constants for the compact timer: register layout, field positions and reset values
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH

// Register offsets (byte-wide registers, plain port)
`define CTM_OFS_CTRL0      3'h0
`define CTM_OFS_CTRL1      3'h1
`define CTM_OFS_CNT_LO     3'h2
`define CTM_OFS_CNT_HI     3'h3
`define CTM_OFS_CMPA_LO    3'h4
`define CTM_OFS_CMPA_HI    3'h5
`define CTM_OFS_FLAGS      3'h6

// Control 0 fields
`define CTM_C0_ON_BIT      3
`define CTM_C0_RP_LSB      0
`define CTM_C0_RP_MSB      2

// Control 1 fields
`define CTM_C1_MODE_LSB    6
`define CTM_C1_MODE_MSB    7
`define CTM_C1_IO_LSB      4
`define CTM_C1_IO_MSB      5
`define CTM_C1_OC_BIT      3
`define CTM_C1_POL_BIT     2
`define CTM_C1_DPX_BIT     1
`define CTM_C1_CCLR_BIT    0

// Flag register fields
`define CTM_FL_A_BIT       0
`define CTM_FL_P_BIT       1

// Mode encodings
`define CTM_MODE_CMP       2'h0
`define CTM_MODE_PWM       2'h2
`define CTM_MODE_TMR       2'h3

// Pin action encodings
`define CTM_IO_NONE        2'h0
`define CTM_IO_LOW         2'h1
`define CTM_IO_HIGH        2'h2
`define CTM_IO_TOGGLE      2'h3
`define CTM_IO_FORCE_OFF   2'h0
`define CTM_IO_FORCE_ON    2'h1
`define CTM_IO_PWM         2'h2

// Reset values and counter maximum
`define CTM_RST_CTRL       8'h00
`define CTM_RST_CNT        10'h000
`define CTM_CNT_MAX        10'h3ff

`endif

// ### tb/ctm_timer_assertions.sv
// Port-level assertions for the compact timer
`timescale 1ns/1ps
module ctm_timer_assertions (
   // Clock and reset
   input wire       mclk,
   input wire       rst,
   // Inputs
   input wire       tick,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   // Outputs
   input wire [7:0] reg_rdata,
   input wire       timer_out_pin0,
   input wire       timer_out_pin1,
   input wire       timer_out_oe,
   input wire       match_a_flag,
   input wire       match_p_flag
);
   // Shadow of control 1, lands on the same edge as the design's copy
   reg [7:0] c1_q;
   always @(posedge mclk or posedge rst) begin
      if (rst)
         c1_q <= 8'h00;
      else if (reg_wr && reg_addr == 3'h1)
         c1_q <= reg_wdata;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_oe; timer_out_oe == (c1_q[7:6] != 2'h3); endproperty
   a_oe: assert property (p_oe) else $error("pin enable wrong for mode");
   property p_tmr_pin; (c1_q[7:6] == 2'h3) [*3] |-> !timer_out_pin0 && !timer_out_pin1; endproperty
   a_tmr_pin: assert property (p_tmr_pin) else $error("pin driven in timer mode");
   property p_no_pflag; $rose(match_p_flag) |-> !c1_q[0] || c1_q[7:6] == 2'h2; endproperty
   a_no_pflag: assert property (p_no_pflag) else $error("P flag with A clearing");
   property p_a_sticky; $fell(match_a_flag) |-> $past(reg_wr && reg_addr == 3'h6 && reg_wdata[0]); endproperty
   a_a_sticky: assert property (p_a_sticky) else $error("A flag dropped by itself");
   property p_a_tick; $rose(match_a_flag) |-> $past(tick); endproperty
   a_a_tick: assert property (p_a_tick) else $error("A flag without count");
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_rd_flags; $past(reg_rd && reg_addr == 3'h6) |-> reg_rdata == {6'h00, $past(match_p_flag), $past(match_a_flag)}; endproperty
   a_rd_flags: assert property (p_rd_flags) else $error("flag read mismatch");
   property p_unmap; $past(reg_rd && reg_addr == 3'h7) |-> reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // ctm_timer_assertions
bind ctm_timer ctm_timer_assertions u_chk (.mclk(mclk), .rst(rst), .tick(tick), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .timer_out_pin0(timer_out_pin0), .timer_out_pin1(timer_out_pin1), .timer_out_oe(timer_out_oe),
   .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

// ### tb/ctm_load.sv
// Load on the timer pin: counts driven-high cycles since the last clear
`timescale 1ns/1ps
module ctm_load (
   // Clock
   input wire     mclk,
   // Pin and window clear
   input wire     pin,
   input wire     oe,
   input wire     clr,
   // Measured high time
   output integer hi_n
);
   always @(posedge mclk) begin
      if (clr)
         hi_n <= 0;
      else if (oe && pin)
         hi_n <= hi_n + 1;
   end
endmodule // ctm_load

// ### tb/test_ctm_timer.sv
// Self-checking bench for the compact timer
`timescale 1ns/1ps
module test_ctm_timer;
   reg        mclk = 1'b0;
   reg        rst = 1'b1;
   reg        tick = 1'b1;
   reg  [2:0] ad = 3'h0;
   reg  [7:0] wd = 8'h00;
   reg        wr_s = 1'b0;
   reg        rd_s = 1'b0;
   reg        clr = 1'b0;
   reg  [7:0] d;
   reg [31:0] t;
   reg [31:0] rs = 32'h000158c8;
   wire [7:0] rdata;
   wire       pin0, pin1, oe, fa, fp;
   integer    hi_n, i, a, e;
   integer    n_mismatch = 0;
   integer    n_tests = 0;
   ctm_timer dut (.mclk(mclk), .rst(rst), .tick(tick), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr_s),
      .reg_rd(rd_s), .reg_rdata(rdata), .timer_out_pin0(pin0), .timer_out_pin1(pin1),
      .timer_out_oe(oe), .match_a_flag(fa), .match_p_flag(fp));
   ctm_load u_load (.mclk(mclk), .pin(pin0), .oe(oe), .clr(clr), .hi_n(hi_n));
   always #5 mclk = ~mclk;
   function [31:0] xs(input [31:0] s);
      begin
         s = s ^ (s << 13);
         s = s ^ (s >> 17);
         xs = s ^ (s << 5);
      end
   endfunction
   task chk(input ok, input [8*12-1:0] m);
      begin
         n_tests = n_tests + 1;
         if (!ok) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t %0s", $time, m);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_tests, n_mismatch);
         if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge mclk);
   endtask
   task wr(input [2:0] a_i, input [7:0] d_i);
      begin
         @(posedge mclk);
         ad <= a_i;
         wd <= d_i;
         wr_s <= 1'b1;
         @(posedge mclk);
         wr_s <= 1'b0;
      end
   endtask
   task rd(input [2:0] a_i);
      begin
         @(posedge mclk);
         ad <= a_i;
         rd_s <= 1'b1;
         @(posedge mclk);
         rd_s <= 1'b0;
         #1 d = rdata;
      end
   endtask
   // Mode and pin action only change with the counter off
   task start(input [7:0] c1, input [7:0] al, input [2:0] rp);
      begin
         wr(3'h0, 8'h00);
         wr(3'h6, 8'h03);
         wr(3'h1, c1);
         wr(3'h4, al);
         wr(3'h5, 8'h00);
         wr(3'h0, {5'h01, rp});
      end
   endtask
   initial begin
      #1000000;
      n_mismatch = n_mismatch + 1;
      report_and_stop;
   end
   initial begin
      cyc(2);
      rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         rd(i[2:0]);
         chk(d === 8'h00, "reset value");
      end
      // Every pin action, both initial levels, both polarities
      for (i = 0; i < 8; i = i + 1) begin
         rs = xs(rs);
         a = 10 + rs % 50;
         e = i[0] ^ i[2];
         start({2'h0, i[1:0], e[0], i[2], 2'h0}, a[7:0], 3'h0);
         cyc(5);
         chk(pin0 === (e[0] ^ i[2]), "init level");
         cyc(80);
         e = (i[1:0] == 2'h0) ? e : (i[1:0] == 2'h3) ? 1 - e : i[1];
         chk(pin0 === (e[0] ^ i[2]) && pin1 === pin0, "pin action");
         chk(fa === 1'b1, "A flag");
      end
      // Clear on P match, then on A match with P below A
      for (i = 0; i < 2; i = i + 1) begin
         start({7'h00, i[0]}, i[0] ? 8'hc8 : 8'h28, 3'h1);
         cyc(300);
         chk(fa === 1'b1 && fp === (i == 0), "cmp flags");
         rd(3'h3);
         chk(d === 8'h00, "cmp clear");
      end
      start(8'hc1, 8'h00, 3'h0);
      cyc(1100);
      chk(fa === 1'b0 && oe === 1'b0 && pin0 === 1'b0, "tmr mode");
      rd(3'h3);
      chk(d === 8'h00, "wrap");
      // Duty measured by the load over 512 clocks: four 128-clock periods, or 100-clock periods with swap
      for (i = 0; i < 4; i = i + 1) begin
         t = i == 0 ? 32'ha9200080 : i == 1 ? 32'hac200180 : i == 2 ? 32'haa640200 : 32'h89200000;
         start(t[31:24], t[23:16], 3'h1);
         cyc(300);
         clr <= 1'b1;
         cyc(1);
         clr <= 1'b0;
         cyc(512);
         e = t[15:0];
         chk(hi_n >= e - 8 && hi_n <= e + 8, "pwm duty");
         chk(fp === (i != 2), "pwm P flag");
      end
      report_and_stop;
   end
endmodule // test_ctm_timer
